// file: hdl/tcl_pkg.sv
// constants and types shared by the touch configuration loader
package tcl_pkg;

	// clock and nonvolatile timing
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned ERASE_TIME_US  = 20;
	localparam int unsigned WRITE_TIME_US  = 5;
	localparam logic [11:0] ERASE_CYCLES   = 12'(ERASE_TIME_US * CLK_MHZ);
	localparam logic [11:0] WRITE_CYCLES   = 12'(WRITE_TIME_US * CLK_MHZ);

	// i2c addressing and answers
	localparam logic [7:0]  LOAD_ADDR      = 8'hc0;
	localparam logic [7:0]  STAT_VALID     = 8'h80;
	localparam logic [7:0]  STAT_INVALID   = 8'h01;

	// profile layout in the nonvolatile array
	localparam int unsigned NVM_BYTES      = 512;
	localparam logic [8:0]  PROF_BYTES     = 9'd510;
	localparam logic [8:0]  CRC_HI_IDX     = 9'd510;
	localparam logic [8:0]  CRC_LO_IDX     = 9'd511;
	localparam logic [8:0]  SLAVE_ADDR_IDX = 9'h000;
	localparam logic [3:0]  PKT_BYTES      = 4'h8;
	localparam logic [3:0]  CRC_BYTES      = 4'h2;

	// crc
	localparam logic [15:0] CRC_POLY       = 16'h1021;
	localparam logic [15:0] CRC_INIT       = 16'hffff;

	// fifo in the receive path
	localparam int unsigned FIFO_WIDTH     = 9;
	localparam int unsigned FIFO_DEPTH     = 32;

	// command and event types, low nibble of the first data byte
	typedef enum logic [3:0] {
		TCL_EV_TOUCH   = 4'h0,
		TCL_EV_RELEASE = 4'h1,
		TCL_CMD_MODE   = 4'h8,
		TCL_CMD_UNLOCK = 4'h9,
		TCL_CMD_ERASE  = 4'ha,
		TCL_CMD_WRITE  = 4'hb,
		TCL_CMD_CRC    = 4'hc
	} tcl_type_t;

	typedef enum logic [2:0] {
		TCL_I_IDLE   = 3'b000,
		TCL_I_ADDR   = 3'b001,
		TCL_I_ACK_A  = 3'b010,
		TCL_I_RX     = 3'b011,
		TCL_I_ACK_RX = 3'b100,
		TCL_I_TX     = 3'b101,
		TCL_I_ACK_TX = 3'b110,
		TCL_I_IGNORE = 3'b111
	} tcl_i2c_t;

	typedef enum logic [1:0] {
		TCL_E_IDLE  = 2'b00,
		TCL_E_ERASE = 2'b01,
		TCL_E_WAIT  = 2'b10,
		TCL_E_MODE  = 2'b11
	} tcl_eng_t;

endpackage : tcl_pkg

// file: hdl/tcl_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module tcl_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 32
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} tcl_fifo_st_t;

	tcl_fifo_st_t     r;
	tcl_fifo_st_t     next_r;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
	assign out_valid = (r.cnt != '0);
	assign out_data  = mem[r.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_r = r;
		if (push) begin
			next_r.wp = r.wp + 1'b1;
		end
		if (pop) begin
			next_r.rp = r.rp + 1'b1;
		end
		next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// storage is not reset; occupancy alone marks what is live
	always_ff @(posedge clk) begin
		if (push) begin
			mem[r.wp] <= in_data;
		end
	end

endmodule : tcl_fifo

// file: hdl/tcl_loader.sv
// i2c slave front end: configuration loading, validity check, mode switch
`timescale 1ns/100ps

module tcl_loader (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// i2c pins, sda open drain
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// interrupt pin, chip select while loading
	input  wire logic       int_i,
	output logic            int_o,
	output logic            int_oe,
	// sensing engine events
	input  wire logic       evt_valid,
	input  wire logic       evt_release,
	input  wire logic [3:0] evt_sensor,
	// status and event packet bytes
	output logic            qual_en,
	output logic            evt_strobe,
	output logic [7:0]      evt_hdr,
	output logic [7:0]      evt_desc,
	output logic            prof_valid
);
	typedef struct packed {
		tcl_pkg::tcl_i2c_t i2c;
		logic [3:0]        bitcnt;
		logic [7:0]        shreg;
		logic              rw;
		logic              first;
		logic              mack;
		logic              sda_oe;
		logic              scl_m;
		logic              scl_s;
		logic              scl_p;
		logic              sda_m;
		logic              sda_s;
		logic              sda_p;
		logic              int_m;
		logic              int_s;
		logic              sensing;
		logic              unlocked;
		logic [3:0]        cmd;
		logic [3:0]        cnt;
		tcl_pkg::tcl_eng_t eng;
		logic [8:0]        wptr;
		logic [8:0]        eidx;
		logic [11:0]       wait_cnt;
		logic              crc_run;
		logic              crc_done;
		logic [8:0]        crc_idx;
		logic [15:0]       crc_acc;
		logic [3:0]        evt_cnt;
		logic [7:0]        evt_hdr;
		logic [7:0]        evt_desc;
		logic              evt_strobe;
	} tcl_state_t;

	tcl_state_t r;
	tcl_state_t next_r;

	// nonvolatile profile image, bytes 510/511 hold the stored crc
	logic [7:0] nvm [tcl_pkg::NVM_BYTES];
	logic       mem_we;
	logic [8:0] mem_addr;
	logic [7:0] mem_wdata;

	logic       fifo_in_valid;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic       fifo_out_ready;
	logic [8:0] fifo_out_data;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic       nvm_busy;
	logic       valid;
	logic [7:0] status;
	logic       addr_ok;
	logic       byte_ok;

	function automatic logic [15:0] crc_byte(input logic [15:0] acc,
	                                         input logic [7:0]  din);
		logic [15:0] a;
		a = acc ^ {din, 8'h00};
		for (int i = 0; i < 8; i++) begin
			a = a[15] ? ({a[14:0], 1'b0} ^ tcl_pkg::CRC_POLY)
			          : {a[14:0], 1'b0};
		end
		return a;
	endfunction : crc_byte

	// decode used only by the ack path, to refuse erase and write while busy
	function automatic logic is_nvm_cmd(input logic [3:0] t);
		return (t == tcl_pkg::TCL_CMD_ERASE) || (t == tcl_pkg::TCL_CMD_WRITE);
	endfunction : is_nvm_cmd

	function automatic logic [7:0] sensor_desc(input logic [3:0] idx);
		return {4'h0, idx};
	endfunction : sensor_desc

	tcl_fifo #(
		.WIDTH (tcl_pkg::FIFO_WIDTH),
		.DEPTH (tcl_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   ({r.first, r.shreg}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	assign scl_rise = r.scl_s & ~r.scl_p;
	assign scl_fall = ~r.scl_s & r.scl_p;
	assign start_c  = r.scl_s & r.scl_p & ~r.sda_s & r.sda_p;
	assign stop_c   = r.scl_s & r.scl_p & r.sda_s & ~r.sda_p;

	// queued bytes count as busy so a retry lands after the work drains
	assign nvm_busy = (r.eng != tcl_pkg::TCL_E_IDLE) | fifo_out_valid;
	assign valid    = r.crc_done &&
	                  (r.crc_acc == {nvm[tcl_pkg::CRC_HI_IDX],
	                                 nvm[tcl_pkg::CRC_LO_IDX]});
	assign status   = valid ? tcl_pkg::STAT_VALID
	                        : tcl_pkg::STAT_INVALID;

	always_comb begin
		if (!r.sensing) begin
			addr_ok = (r.shreg[7:1] == tcl_pkg::LOAD_ADDR[7:1]);
		end else begin
			// no event buffer here, so reads are refused
			addr_ok = ~r.shreg[0] &&
			          (r.shreg[7:1] ==
			           nvm[tcl_pkg::SLAVE_ADDR_IDX][7:1]);
		end
		byte_ok = r.sensing ||
		          (fifo_in_ready &&
		           !(r.first && is_nvm_cmd(r.shreg[3:0]) && nvm_busy));
	end

	always_comb begin
		next_r         = r;
		mem_we         = 1'b0;
		mem_addr       = '0;
		mem_wdata      = '0;
		fifo_in_valid  = 1'b0;
		fifo_out_ready = 1'b0;
		next_r.scl_m      = scl_i;
		next_r.scl_s      = r.scl_m;
		next_r.scl_p      = r.scl_s;
		next_r.sda_m      = sda_i;
		next_r.sda_s      = r.sda_m;
		next_r.sda_p      = r.sda_s;
		next_r.int_m      = int_i;
		next_r.int_s      = r.int_m;
		next_r.evt_strobe = 1'b0;

		// i2c bit engine
		if (start_c) begin
			next_r.bitcnt = '0;
			next_r.sda_oe = 1'b0;
			next_r.i2c    = (!r.sensing && r.int_s) ? tcl_pkg::TCL_I_IGNORE
			                                        : tcl_pkg::TCL_I_ADDR;
		end else if (stop_c) begin
			next_r.i2c    = tcl_pkg::TCL_I_IDLE;
			next_r.sda_oe = 1'b0;
		end else begin
			unique case (r.i2c)
				tcl_pkg::TCL_I_IDLE, tcl_pkg::TCL_I_IGNORE: begin
					next_r.sda_oe = 1'b0;
				end
				tcl_pkg::TCL_I_ADDR, tcl_pkg::TCL_I_RX: begin
					if (scl_rise) begin
						next_r.shreg  = {r.shreg[6:0], r.sda_s};
						next_r.bitcnt = r.bitcnt + 4'h1;
					end else if (scl_fall && r.bitcnt == 4'h8) begin
						next_r.bitcnt = '0;
						if (r.i2c == tcl_pkg::TCL_I_ADDR) begin
							next_r.rw    = r.shreg[0];
							next_r.first = 1'b1;
							if (addr_ok) begin
								next_r.i2c    = tcl_pkg::TCL_I_ACK_A;
								next_r.sda_oe = 1'b1;
							end else begin
								next_r.i2c = tcl_pkg::TCL_I_IGNORE;
							end
						end else if (byte_ok) begin
							fifo_in_valid = ~r.sensing;
							next_r.first  = 1'b0;
							next_r.i2c    = tcl_pkg::TCL_I_ACK_RX;
							next_r.sda_oe = 1'b1;
						end else begin
							next_r.i2c = tcl_pkg::TCL_I_IGNORE;
						end
					end
				end
				tcl_pkg::TCL_I_ACK_A, tcl_pkg::TCL_I_ACK_RX: begin
					if (scl_fall) begin
						if (r.i2c == tcl_pkg::TCL_I_ACK_A && r.rw) begin
							// plain read carries no command byte
							next_r.i2c    = tcl_pkg::TCL_I_TX;
							next_r.shreg  = status;
							next_r.sda_oe = ~status[7];
						end else begin
							next_r.i2c    = tcl_pkg::TCL_I_RX;
							next_r.sda_oe = 1'b0;
						end
					end
				end
				tcl_pkg::TCL_I_TX: begin
					if (scl_rise) begin
						next_r.bitcnt = r.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (r.bitcnt == 4'h8) begin
							next_r.i2c    = tcl_pkg::TCL_I_ACK_TX;
							next_r.sda_oe = 1'b0;
							next_r.bitcnt = '0;
						end else begin
							next_r.sda_oe = ~r.shreg[3'd7 - r.bitcnt[2:0]];
						end
					end
				end
				tcl_pkg::TCL_I_ACK_TX: begin
					if (scl_rise) begin
						next_r.mack = ~r.sda_s;
					end else if (scl_fall) begin
						if (r.mack) begin
							next_r.i2c    = tcl_pkg::TCL_I_TX;
							next_r.shreg  = status;
							next_r.sda_oe = ~status[7];
						end else begin
							next_r.i2c = tcl_pkg::TCL_I_IGNORE;
						end
					end
				end
			endcase
		end

		// command engine
		unique case (r.eng)
			tcl_pkg::TCL_E_IDLE: begin
				if (fifo_out_valid) begin
					fifo_out_ready = 1'b1;
					if (fifo_out_data[8]) begin
						next_r.cmd = fifo_out_data[3:0];
						next_r.cnt = '0;
						if (fifo_out_data[3:0] == tcl_pkg::TCL_CMD_MODE) begin
							next_r.eng = tcl_pkg::TCL_E_MODE;
						end else if (fifo_out_data[3:0] ==
						             tcl_pkg::TCL_CMD_UNLOCK) begin
							next_r.unlocked = 1'b1;
						end else if (fifo_out_data[3:0] ==
						             tcl_pkg::TCL_CMD_ERASE && r.unlocked) begin
							next_r.eng  = tcl_pkg::TCL_E_ERASE;
							next_r.eidx = '0;
							next_r.wptr = '0;
						end
					end else if (r.unlocked && r.cmd == tcl_pkg::TCL_CMD_WRITE &&
					             r.cnt < tcl_pkg::PKT_BYTES) begin
						mem_addr   = r.wptr + {5'h00, r.cnt};
						mem_we     = (mem_addr < tcl_pkg::PROF_BYTES);
						mem_wdata  = fifo_out_data[7:0];
						next_r.cnt = r.cnt + 4'h1;
						if (r.cnt == tcl_pkg::PKT_BYTES - 4'h1) begin
							next_r.wptr     = r.wptr + {5'h00, tcl_pkg::PKT_BYTES};
							next_r.eng      = tcl_pkg::TCL_E_WAIT;
							next_r.wait_cnt = tcl_pkg::WRITE_CYCLES;
						end
					end else if (r.unlocked && r.cmd == tcl_pkg::TCL_CMD_CRC &&
					             r.cnt < tcl_pkg::CRC_BYTES) begin
						// stored high byte first
						mem_we     = 1'b1;
						mem_addr   = tcl_pkg::CRC_HI_IDX + {5'h00, r.cnt};
						mem_wdata  = fifo_out_data[7:0];
						next_r.cnt = r.cnt + 4'h1;
					end
				end
			end
			tcl_pkg::TCL_E_ERASE: begin
				mem_we      = 1'b1;
				mem_addr    = r.eidx;
				mem_wdata   = 8'hff;
				next_r.eidx = r.eidx + 9'h001;
				if (r.eidx == tcl_pkg::CRC_LO_IDX) begin
					next_r.eng      = tcl_pkg::TCL_E_WAIT;
					next_r.wait_cnt = tcl_pkg::ERASE_CYCLES;
				end
			end
			tcl_pkg::TCL_E_WAIT: begin
				next_r.wait_cnt = r.wait_cnt - 12'h001;
				if (r.wait_cnt <= 12'h001) begin
					next_r.eng = tcl_pkg::TCL_E_IDLE;
				end
			end
			tcl_pkg::TCL_E_MODE: begin
				// wait for a settled check before deciding
				if (r.crc_done && !mem_we) begin
					next_r.eng = tcl_pkg::TCL_E_IDLE;
					if (valid) begin
						next_r.sensing = 1'b1;
						next_r.evt_cnt = 4'h0;
					end
				end
			end
		endcase

		// background crc; any write restarts it
		if (mem_we) begin
			next_r.crc_run  = 1'b1;
			next_r.crc_done = 1'b0;
			next_r.crc_idx  = '0;
			next_r.crc_acc  = tcl_pkg::CRC_INIT;
		end else if (r.crc_run) begin
			// erased bytes read 0xff, so padding needs no special case
			next_r.crc_acc = crc_byte(r.crc_acc, nvm[r.crc_idx]);
			next_r.crc_idx = r.crc_idx + 9'h001;
			if (r.crc_idx == tcl_pkg::PROF_BYTES - 9'h001) begin
				next_r.crc_run  = 1'b0;
				next_r.crc_done = 1'b1;
			end
		end

		// event packet bytes, only once sensing
		if (r.sensing && evt_valid) begin
			next_r.evt_hdr    = {r.evt_cnt, evt_release ? tcl_pkg::TCL_EV_RELEASE
			                                            : tcl_pkg::TCL_EV_TOUCH};
			next_r.evt_desc   = sensor_desc(evt_sensor);
			next_r.evt_cnt    = r.evt_cnt + 4'h1;
			next_r.evt_strobe = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			r          <= '0;
			r.scl_m    <= 1'b1;
			r.scl_s    <= 1'b1;
			r.scl_p    <= 1'b1;
			r.sda_m    <= 1'b1;
			r.sda_s    <= 1'b1;
			r.sda_p    <= 1'b1;
			r.int_m    <= 1'b1;
			r.int_s    <= 1'b1;
			r.crc_run  <= 1'b1;
			r.crc_acc  <= tcl_pkg::CRC_INIT;
		end else begin
			r <= next_r;
		end
	end

	// nonvolatile: survives reset, so no reset branch
	always_ff @(posedge clk) begin
		if (mem_we) begin
			nvm[mem_addr] <= mem_wdata;
		end
	end

	assign sda_o      = 1'b0;
	assign sda_oe     = r.sda_oe;
	assign int_o      = 1'b1;
	assign int_oe     = r.sensing;
	assign qual_en    = r.sensing;
	assign evt_strobe = r.evt_strobe;
	assign evt_hdr    = r.evt_hdr;
	assign evt_desc   = r.evt_desc;
	assign prof_valid = valid;

endmodule : tcl_loader

// file: dv/tcl_loader_props.sv
// assertions on the configuration loader ports
`timescale 1ns/100ps
module tcl_loader_props (
	// clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// pins
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic       int_i,
	input wire logic       int_o,
	input wire logic       int_oe,
	// events and status
	input wire logic       evt_valid,
	input wire logic       evt_release,
	input wire logic [3:0] evt_sensor,
	input wire logic       qual_en,
	input wire logic       evt_strobe,
	input wire logic [7:0] evt_hdr,
	input wire logic [7:0] evt_desc,
	input wire logic       prof_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [3:0] cnt;
	// restarts whenever sensing is off, so entry always counts from zero
	always_ff @(posedge clk) begin
		if (!nrst || !qual_en)
			cnt <= 4'h0;
		else if (evt_strobe)
			cnt <= cnt + 4'h1;
	end
	a_reset_quiet: assert property (
		$rose(nrst) |-> !qual_en && !int_oe && !sda_oe && !evt_strobe)
		else $error("outputs active after reset");
	a_valid_switch: assert property (
		$rose(qual_en) |-> $past(prof_valid))
		else $error("sensing entered with bad profile");
	a_sense_sticks: assert property (qual_en |=> qual_en)
		else $error("sensing mode left");
	a_no_early_evt: assert property (
		evt_strobe |-> $past(qual_en && evt_valid))
		else $error("event without sensing");
	a_desc_index: assert property (
		evt_valid && qual_en |=> evt_strobe
		&& evt_desc == {4'h0, $past(evt_sensor)}
		&& evt_hdr[3:0] == {3'h0, $past(evt_release)})
		else $error("event bytes wrong");
	a_count_step: assert property (
		evt_strobe |-> evt_hdr[7:4] == cnt)
		else $error("event counter wrong");
	a_cs_input: assert property (!qual_en |-> !int_oe)
		else $error("select pin driven in loading");
	a_ack_needs_cs: assert property (
		!qual_en && sda_oe |-> !int_i)
		else $error("answer while unselected");
	cover property ($rose(qual_en));
	cover property (evt_strobe && evt_hdr[7:4] == 4'hf);
	cover property (sda_oe && !qual_en);
endmodule : tcl_loader_props

bind tcl_loader tcl_loader_props u_props (
	.clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .int_i(int_i), .int_o(int_o),
	.int_oe(int_oe), .evt_valid(evt_valid), .evt_release(evt_release),
	.evt_sensor(evt_sensor), .qual_en(qual_en), .evt_strobe(evt_strobe),
	.evt_hdr(evt_hdr), .evt_desc(evt_desc), .prof_valid(prof_valid));

// file: dv/tcl_host.sv
// i2c master model of the host processor
`timescale 1ns/100ps
module tcl_host (
	// clock
	input wire logic clk,
	// bus lines, pulls are high while pulling low
	output logic     scl,
	output logic     sda_pull,
	output logic     cs_pull,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		cs_pull = 1'b0;
	end
	// 12 ns steps: 48 ns bits, scl 24 ns high and 24 ns low, free of clk
	task automatic tick();
		#12;
	endtask : tick
	// sda moves mid-low and is read mid-high, clear of both scl edges
	task automatic bit_x(input logic b, output logic r);
		sda_pull <= !b;
		tick();
		scl <= 1'b1;
		tick();
		r = sda;
		tick();
		scl <= 1'b0;
		tick();
	endtask : bit_x
	task automatic byte_x(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(last, r);
		ack = !r;
	endtask : byte_x
	task automatic start(input logic sel);
		cs_pull <= sel;
		tick();
		sda_pull <= 1'b1;
		tick();
		scl <= 1'b0;
		tick();
	endtask : start
	task automatic stop();
		sda_pull <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sda_pull <= 1'b0;
		tick();
		cs_pull <= 1'b0;
		tick();
	endtask : stop
	// n counts acked bytes, address included; gives up at a nack
	task automatic write_pkt(input logic [7:0] addr, input logic sel,
		input logic [7:0] q[$], output int n);
		logic [7:0] v;
		logic       a;
		n = 0;
		start(sel);
		byte_x(addr, 1'b1, v, a);
		for (int i = 0; i <= q.size() && a; i++) begin
			n++;
			if (i < q.size())
				byte_x(q[i], 1'b1, v, a);
		end
		stop();
	endtask : write_pkt
	task automatic read_st(input logic [7:0] addr, output logic [7:0] d,
		output logic a);
		logic [7:0] v;
		logic       r;
		d = 8'h00;
		start(1'b1);
		byte_x(addr, 1'b1, v, a);
		if (a)
			byte_x(8'hff, 1'b1, d, r);
		stop();
	endtask : read_st
endmodule : tcl_host

// file: dv/tb.sv
// self-checking bench of the configuration loader
`timescale 1ns/100ps
module tb;
	logic       clk;
	logic       nrst;
	logic       evt_valid;
	logic       evt_release;
	logic [3:0] evt_sensor;
	logic       scl, sda_pull, cs_pull, sda, int_w;
	logic       sda_o, sda_oe, int_o, int_oe, qual_en;
	logic       evt_strobe, prof_valid;
	logic [7:0] evt_hdr, evt_desc, st;
	logic [7:0] prof [510];
	logic [7:0] q [$];
	logic [15:0] crc;
	logic       ak;
	int         failures = 0;
	int         checks_done = 0;
	int         cycles = 0;
	int         n;
	// both lines pulled up
	assign sda = !(sda_pull || (sda_oe && !sda_o));
	assign int_w = cs_pull ? 1'b0 : (int_oe ? int_o : 1'b1);
	tcl_loader DUT (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .int_i(int_w), .int_o(int_o),
		.int_oe(int_oe), .evt_valid(evt_valid), .evt_release(evt_release),
		.evt_sensor(evt_sensor), .qual_en(qual_en), .evt_strobe(evt_strobe),
		.evt_hdr(evt_hdr), .evt_desc(evt_desc), .prof_valid(prof_valid));
	tcl_host u_host (.clk(clk), .scl(scl), .sda_pull(sda_pull),
		.cs_pull(cs_pull), .sda(sda));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
		c = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++)
			c = c[15] ? (c << 1) ^ tcl_pkg::CRC_POLY : c << 1;
		return c;
	endfunction : crc_step
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic t_select();
		@(posedge clk);
		evt_valid <= 1'b1;
		@(posedge clk);
		evt_valid <= 1'b0;
		cyc(2);
		check(evt_strobe, 1'b0, "event in loading");
		check(qual_en, 1'b0, "sensing after reset");
		q = {8'h09};
		u_host.write_pkt(8'hc0, 1'b0, q, n);
		check(16'(n), 0, "unselected acked");
		u_host.write_pkt(8'hc2, 1'b1, q, n);
		check(16'(n), 0, "wrong address acked");
		$display("select test done");
	endtask : t_select
	task automatic t_load();
		// only 16 bytes sent: the rest must count as erased padding
		for (int i = 0; i < 510; i++)
			prof[i] = i == 0 ? 8'h5a : (i < 16 ? 8'(i * 19) : 8'hff);
		crc = tcl_pkg::CRC_INIT;
		for (int i = 0; i < 510; i++)
			crc = crc_step(crc, prof[i]);
		check(crc_step(16'hffff, 8'h63), 16'hbd35, "crc model");
		q = {8'h09};
		u_host.write_pkt(8'hc0, 1'b1, q, n);
		q = {8'h1a};
		u_host.write_pkt(8'hc0, 1'b1, q, n);
		check(16'(n), 2, "erase refused");
		for (int k = 0; k < 2; k++) begin
			q = {8'h0b};
			for (int j = 0; j < 8; j++)
				q.push_back(prof[8 * k + j]);
			u_host.write_pkt(8'hc0, 1'b1, q, n);
			check(16'(n), 1, "write taken while busy");
			for (int j = 0; j < 40 && n != 10; j++)
				u_host.write_pkt(8'hc0, 1'b1, q, n);
			check(16'(n), 10, "write never taken");
		end
		cyc(2000);
		u_host.read_st(8'hc1, st, ak);
		check({ak, st}, {1'b1, 8'h01}, "status not invalid");
		check(prof_valid, 1'b0, "erased crc passes");
		q = {8'h08};
		u_host.write_pkt(8'hc0, 1'b1, q, n);
		cyc(1500);
		check(qual_en, 1'b0, "sensing with bad profile");
		q = {8'h0c, crc[15:8], crc[7:0]};
		u_host.write_pkt(8'hc0, 1'b1, q, n);
		cyc(2000);
		u_host.read_st(8'hc1, st, ak);
		check({ak, st}, {1'b1, 8'h80}, "status not valid");
		check(prof_valid, 1'b1, "crc mismatch");
		$display("load test done");
	endtask : t_load
	task automatic t_sense();
		q = {8'h08};
		u_host.write_pkt(8'hc0, 1'b1, q, n);
		for (int j = 0; j < 2000 && qual_en !== 1'b1; j++)
			@(posedge clk);
		cyc(4);
		check(qual_en, 1'b1, "no sensing");
		q = {8'h09};
		u_host.write_pkt(8'hc0, 1'b0, q, n);
		check(16'(n), 0, "loading address kept");
		u_host.write_pkt(8'h5a, 1'b0, q, n);
		check(16'(n), 2, "profile address refused");
		check(qual_en, 1'b1, "sensing left");
		check({int_oe, int_o}, 2'b11, "select pin not an output");
		$display("sense test done");
	endtask : t_sense
	task automatic t_events();
		for (int i = 0; i < 17; i++) begin
			@(posedge clk);
			evt_valid <= 1'b1;
			evt_release <= i[0];
			evt_sensor <= 4'(i % 12);
			@(posedge clk);
			evt_valid <= 1'b0;
			#1;
			check(evt_strobe, 1'b1, "no strobe");
			check(evt_desc, 8'(i % 12), "sensor index");
			check(evt_hdr, {4'(i), 3'h0, i[0]}, "header");
		end
		$display("event test done");
	endtask : t_events
	// expected run is about 15000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		nrst = 1'b0;
		evt_valid = 1'b0;
		evt_release = 1'b0;
		evt_sensor = 4'h0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_select();
		t_load();
		t_sense();
		t_events();
		complete_run();
	end
endmodule : tb
